// ---- include/scp_pkg.sv ----
// Shared constants and types of the charger SMBus target port
// Assumes a 50 MHz system clock and the bus pins sampled through synchronisers
package scp_pkg;

  // ****************************************
  // Bus addressing
  // ****************************************
  localparam logic [6:0] TARGET_ADDR = 7'h09;
  localparam logic [7:0] CMD_OPTION_CONTROL = 8'h12;
  localparam logic [7:0] CMD_BATTERY_CURRENT = 8'h14;
  localparam logic [7:0] CMD_BATTERY_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_ADAPTER_LIMIT = 8'h3F;
  localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
  localparam logic [7:0] CMD_PART_ID = 8'hFF;

  // ****************************************
  // Reset values and identity defaults
  // ****************************************
  localparam logic [15:0] RST_OPTION_CONTROL = 16'h0000;
  localparam logic [15:0] RST_BATTERY_CURRENT = 16'h0000;
  localparam logic [15:0] RST_BATTERY_VOLTAGE = 16'h0000;
  localparam logic [15:0] RST_ADAPTER_LIMIT = 16'h0000;
  // Arbitrary identity values
  localparam logic [15:0] DEF_MAKER_ID = 16'h00A5;
  localparam logic [15:0] DEF_PART_ID = 16'h005A;

  // ****************************************
  // Byte framing
  // ****************************************
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_LOW = 2'h2;
  localparam logic [1:0] IDX_HIGH = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 50000;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYCLES_DEF = TIMEOUT_MS * CLK_KHZ;
  localparam int TIMEOUT_CNT_W = 21;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100,
    ST_WAIT = 3'b101
  } scp_state_t;

  typedef struct packed {
    logic [15:0] optionControl;
    logic [15:0] batteryCurrentSetpoint;
    logic [15:0] batteryVoltageSetpoint;
    logic [15:0] adapterCurrentLimit;
  } scp_settings_t;

  typedef struct packed {
    logic en;
    logic [7:0] cmd;
    logic [15:0] data;
  } scp_write_t;

  // Command accepted by the port
  function automatic logic scp_known_cmd(input logic [7:0] c);
    return (c == CMD_OPTION_CONTROL) || (c == CMD_BATTERY_CURRENT) ||
           (c == CMD_BATTERY_VOLTAGE) || (c == CMD_ADAPTER_LIMIT) ||
           (c == CMD_MAKER_ID) || (c == CMD_PART_ID);
  endfunction

endpackage

// ---- logic/scp_reg_file.sv ----
// Setting and identification words of the charger port
// Assumes one write strobe per cycle from the bus engine on the same clock
`timescale 1ns/1ps
`default_nettype none
module scp_reg_file #(
  parameter logic [15:0] MAKER_ID = scp_pkg::DEF_MAKER_ID,
  parameter logic [15:0] PART_ID = scp_pkg::DEF_PART_ID
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire scp_pkg::scp_write_t wr,
  input wire logic [7:0] rdCmd,
  output var logic [15:0] rdData,
  output var scp_pkg::scp_settings_t settings
);
  import scp_pkg::*;

  // ****************************************
  // Read selection
  // ****************************************
  logic [15:0] rdSel;
  assign rdSel = (rdCmd == CMD_OPTION_CONTROL) ? settings.optionControl :
                 (rdCmd == CMD_BATTERY_CURRENT) ? settings.batteryCurrentSetpoint :
                 (rdCmd == CMD_BATTERY_VOLTAGE) ? settings.batteryVoltageSetpoint :
                 (rdCmd == CMD_ADAPTER_LIMIT) ? settings.adapterCurrentLimit :
                 (rdCmd == CMD_MAKER_ID) ? MAKER_ID :
                 (rdCmd == CMD_PART_ID) ? PART_ID : 16'h0000;

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      settings <= {RST_OPTION_CONTROL, RST_BATTERY_CURRENT,
                   RST_BATTERY_VOLTAGE, RST_ADAPTER_LIMIT};
      rdData <= 16'h0000;
    end else begin
      rdData <= rdSel;
      if (wr.en) begin
        case (wr.cmd)
          CMD_OPTION_CONTROL: settings.optionControl <= wr.data;
          CMD_BATTERY_CURRENT: settings.batteryCurrentSetpoint <= wr.data;
          CMD_BATTERY_VOLTAGE: settings.batteryVoltageSetpoint <= wr.data;
          CMD_ADAPTER_LIMIT: settings.adapterCurrentLimit <= wr.data;
          default: ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/scp_smbus_target.sv ----
// SMBus target engine of the charger port: word read and word write
// Assumes open-drain bus wires resolved outside, pins asynchronous to clk_sys
//
// Summary of operation
// - Target only, never starts or clocks
// - Answer only address 0b0001001
// - Only word read and word write
// - Commands 0xFF, 0xFE return identity words
// - Active only when supply and adapter good
// - Clock high, data falling begins transfer
// - Clock high, data rising ends, go idle
// - Data changes only while clock low
// - Eight-bit bytes, sampled on clock rise
// - Ninth clock carries receiver acknowledge low
// - Whole transaction between START and STOP
// - Most significant bit first
// - Write: address, command, low, high, acked
// - Setpoints at 0x14, 0x15, 0x3F read/write
// - Read: repeated START, low then high
// - Direction bit low write, high read
// - Clock low past 25 ms aborts transfer
`timescale 1ns/1ps
`default_nettype none
module scp_smbus_target #(
  parameter int TIMEOUT_CYCLES = scp_pkg::TIMEOUT_CYCLES_DEF,
  parameter logic [15:0] MAKER_ID = scp_pkg::DEF_MAKER_ID,
  parameter logic [15:0] PART_ID = scp_pkg::DEF_PART_ID
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic supplyLockoutOk,
  input wire logic adapterDetectInputOk,
  output logic busActive,
  output scp_pkg::scp_settings_t settings
);
  import scp_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] lockSync;
  logic [1:0] adetSync;
  logic sclPrev;
  logic sdaPrev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      lockSync <= 2'h0;
      adetSync <= 2'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      lockSync <= {lockSync[0], supplyLockoutOk};
      adetSync <= {adetSync[0], adapterDetectInputOk};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  // ****************************************
  // Bus event decode
  // ****************************************
  wire sclH = sclSync[1];
  wire sdaH = sdaSync[1];
  wire sclRise = sclH & ~sclPrev;
  wire sclFall = ~sclH & sclPrev;
  wire startDet = sclH & sclPrev & ~sdaH & sdaPrev;
  wire stopDet = sclH & sclPrev & sdaH & ~sdaPrev;
  wire busEnabled = lockSync[1] & adetSync[1];

  // ****************************************
  // Engine state
  // ****************************************
  scp_state_t state_reg, state_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [1:0] byteIdx_reg, byteIdx_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cmd_reg, cmd_next;
  logic cmdValid_reg, cmdValid_next;
  logic rnw_reg, rnw_next;
  logic [7:0] dataLow_reg, dataLow_next;
  logic [7:0] txShift_reg, txShift_next;
  logic txHigh_reg, txHigh_next;
  logic masterAck_reg, masterAck_next;
  logic sdaOe_reg, sdaOe_next;
  logic [TIMEOUT_CNT_W-1:0] lowCnt_reg;
  logic wrStrobe;
  logic [15:0] rdData;
  scp_write_t wr;

  // ****************************************
  // Byte decisions
  // ****************************************
  wire byteEnd = (state_reg == ST_RX) && sclFall && (bitCnt_reg == BITS_PER_BYTE);
  wire addrHit = (shift_reg[7:1] == TARGET_ADDR);
  wire rxIsRead = shift_reg[0];
  wire addrOk = addrHit && (!rxIsRead || cmdValid_reg);
  wire ackOk = (byteIdx_reg == IDX_ADDR) ? addrOk :
               (byteIdx_reg == IDX_CMD) ? scp_known_cmd(shift_reg) : 1'b1;
  wire timeout = (lowCnt_reg == TIMEOUT_CNT_W'(TIMEOUT_CYCLES - 1));

  // ****************************************
  // Clock-low timeout counter
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst || state_reg == ST_IDLE || sclH) begin
      lowCnt_reg <= '0;
    end else if (!timeout) begin
      lowCnt_reg <= lowCnt_reg + 1'b1;
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    byteIdx_next = byteIdx_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    cmdValid_next = cmdValid_reg;
    rnw_next = rnw_reg;
    dataLow_next = dataLow_reg;
    txShift_next = txShift_reg;
    txHigh_next = txHigh_reg;
    masterAck_next = masterAck_reg;
    sdaOe_next = sdaOe_reg;
    wrStrobe = 1'b0;
    if (!busEnabled || timeout) begin
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
      cmdValid_next = 1'b0;
    end else if (startDet) begin
      state_next = ST_RX;
      bitCnt_next = 4'h0;
      byteIdx_next = IDX_ADDR;
      sdaOe_next = 1'b0;
    end else if (stopDet) begin
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
      cmdValid_next = 1'b0;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], sdaH};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          if (byteEnd) begin
            if (ackOk) begin
              state_next = ST_ACK;
              sdaOe_next = 1'b1;
              if (byteIdx_reg == IDX_ADDR) begin
                rnw_next = rxIsRead;
              end else if (byteIdx_reg == IDX_CMD) begin
                cmd_next = shift_reg;
                cmdValid_next = 1'b1;
              end else if (byteIdx_reg == IDX_LOW) begin
                dataLow_next = shift_reg;
              end
            end else begin
              state_next = ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            sdaOe_next = 1'b0;
            bitCnt_next = 4'h0;
            if (byteIdx_reg == IDX_ADDR && rnw_reg) begin
              state_next = ST_TX;
              txShift_next = rdData[7:0];
              sdaOe_next = ~rdData[7];
              txHigh_next = 1'b0;
            end else if (byteIdx_reg == IDX_HIGH) begin
              wrStrobe = 1'b1;
              state_next = ST_WAIT;
            end else begin
              state_next = ST_RX;
              byteIdx_next = byteIdx_reg + 2'h1;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_reg == BIT_LAST) begin
              sdaOe_next = 1'b0;
              state_next = ST_TXACK;
            end else begin
              txShift_next = {txShift_reg[6:0], 1'b0};
              sdaOe_next = ~txShift_reg[6];
              bitCnt_next = bitCnt_reg + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            masterAck_next = ~sdaH;
          end
          if (sclFall) begin
            if (masterAck_reg && !txHigh_reg) begin
              state_next = ST_TX;
              txShift_next = rdData[15:8];
              sdaOe_next = ~rdData[15];
              txHigh_next = 1'b1;
              bitCnt_next = 4'h0;
            end else begin
              state_next = ST_WAIT;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= IDX_ADDR;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      cmdValid_reg <= 1'b0;
      rnw_reg <= 1'b0;
      dataLow_reg <= 8'h00;
      txShift_reg <= 8'h00;
      txHigh_reg <= 1'b0;
      masterAck_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      byteIdx_reg <= byteIdx_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      cmdValid_reg <= cmdValid_next;
      rnw_reg <= rnw_next;
      dataLow_reg <= dataLow_next;
      txShift_reg <= txShift_next;
      txHigh_reg <= txHigh_next;
      masterAck_reg <= masterAck_next;
      sdaOe_reg <= sdaOe_next;
    end
  end

  // ****************************************
  // Outputs and register file
  // ****************************************
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;
  assign busActive = (state_reg != ST_IDLE);
  assign wr = '{en: wrStrobe, cmd: cmd_reg, data: {shift_reg, dataLow_reg}};

  scp_reg_file #(
    .MAKER_ID(MAKER_ID),
    .PART_ID(PART_ID)
  ) u_regs (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr(wr),
    .rdCmd(cmd_reg),
    .rdData(rdData),
    .settings(settings)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_byte_end;
    state_reg == ST_RX && sclFall && bitCnt_reg == BITS_PER_BYTE;
  endsequence

  sequence s_released;
    state_reg == ST_WAIT && !sdaOe_reg;
  endsequence

  property p_idle_quiet;
    state_reg == ST_IDLE |-> !sdaOe_reg;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("Data line driven while idle");

  property p_disabled;
    !busEnabled |=> state_reg == ST_IDLE && !sdaOe_reg;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Port active while disabled");

  property p_start;
    busEnabled && !timeout && startDet |=> state_reg == ST_RX && bitCnt_reg == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("Start not taken");

  property p_stop;
    stopDet |=> state_reg == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("Stop not taken");

  property p_drive_low_clock;
    $changed(sdaOe_reg) && $past(busEnabled) |-> !sclH;
  endproperty
  a_drive_low_clock: assert property (p_drive_low_clock)
    else $error("Data drive changed with clock high");

  property p_foreign_addr;
    busEnabled && !timeout && !startDet && !stopDet && byteIdx_reg == IDX_ADDR
      && !addrHit ##0 s_byte_end |=> s_released;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr)
    else $error("Foreign address acknowledged");

  property p_ack_hold;
    busEnabled && !timeout && !startDet && !stopDet && ackOk ##0 s_byte_end
      |=> sdaOe_reg && state_reg == ST_ACK;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("Missing acknowledge");

  property p_commit;
    $changed(settings) |-> $past(wrStrobe) && $past(byteIdx_reg) == IDX_HIGH;
  endproperty
  a_commit: assert property (p_commit)
    else $error("Setting changed without full word");

  property p_timeout;
    timeout |=> state_reg == ST_IDLE && !sdaOe_reg;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Timeout did not abort");

  property p_msb_shift;
    busEnabled && !timeout && !startDet && !stopDet && state_reg == ST_TX && sclFall
      && bitCnt_reg != BIT_LAST |=> sdaOe_reg == !$past(txShift_reg[6]);
  endproperty
  a_msb_shift: assert property (p_msb_shift)
    else $error("Transmit bit order wrong");

endmodule
`default_nettype wire

// ---- verif/scp_host_model.sv ----
// Host controller model acting as bus master toward the charger port
// Assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  // ********************
  // Master transfers
  // ********************
  localparam time T_LOW = 120;
  localparam time T_HIGH = 40;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Start or repeated start, ends with clock low
  task automatic start();
    #20 sdaLow = 1'b0;
    #(T_LOW - 20) scl = 1'b1;
    #80 sdaLow = 1'b1;
    #80 scl = 1'b0;
  endtask
  // One clock: data set while low, sampled at the rise
  task automatic bitCycle(input logic b, output logic s);
    #20 sdaLow = ~b;
    #(T_LOW - 20) scl = 1'b1;
    s = sdaLine;
    #T_HIGH scl = 1'b0;
  endtask
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], s);
    end
    bitCycle(1'b1, s);
    ack = ~s;
  endtask
  task automatic readByte(input logic giveAck, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, d[i]);
    end
    bitCycle(~giveAck, s);
  endtask
  // Stop, then bus free time
  task automatic stop();
    #20 sdaLow = 1'b1;
    #(T_LOW - 20) scl = 1'b1;
    #80 sdaLow = 1'b0;
    #160;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_smbus_charger_slave_port.sv ----
// Self-checking bench of the charger port bus engine
// Assumes the host model as bus master and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
module test_smbus_charger_slave_port;
  import scp_pkg::*;
  // ********************
  // Bench
  // ********************
  localparam int TO_CYC = 400;
  // Arbitrary identity values
  localparam logic [15:0] MAKER = 16'hC3C3;
  localparam logic [15:0] PART = 16'h3C3C;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic supOk = 1'b1;
  logic adOk = 1'b1;
  logic sclW;
  logic hostLow;
  logic sdaOut;
  logic sdaOe;
  logic busActive;
  scp_settings_t settings;
  scp_settings_t expSet;
  wire logic sdaW;
  int fail_count = 0;
  int n_checks = 0;
  assign sdaW = (hostLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  scp_host_model u_host (.scl(sclW), .sdaLow(hostLow), .sdaLine(sdaW));
  scp_smbus_target #(.TIMEOUT_CYCLES(TO_CYC), .MAKER_ID(MAKER), .PART_ID(PART)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .sclIn(sclW), .sdaIn(sdaW), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .supplyLockoutOk(supOk), .adapterDetectInputOk(adOk),
    .busActive(busActive), .settings(settings));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(sdaOe) begin
    if (srst === 1'b0) begin
      check("sdaOe edge clock level", 64'(sclW), 64'h0);
    end
  end
  task automatic wrWord(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d,
                        output logic [3:0] ack);
    u_host.start();
    u_host.writeByte({adr, 1'b0}, ack[3]);
    u_host.writeByte(cmd, ack[2]);
    u_host.writeByte(d[7:0], ack[1]);
    u_host.writeByte(d[15:8], ack[0]);
    u_host.stop();
  endtask
  task automatic rdWord(input logic [7:0] cmd, output logic [15:0] d, output logic [2:0] ack);
    u_host.start();
    u_host.writeByte({TARGET_ADDR, 1'b0}, ack[2]);
    u_host.writeByte(cmd, ack[1]);
    u_host.start();
    u_host.writeByte({TARGET_ADDR, 1'b1}, ack[0]);
    u_host.readByte(1'b1, d[7:0]);
    u_host.readByte(1'b0, d[15:8]);
    u_host.stop();
  endtask
  task automatic tcIdentity();
    logic [15:0] d;
    logic [2:0] a;
    logic [3:0] w;
    rdWord(CMD_MAKER_ID, d, a);
    check("maker id", 64'(d), 64'(MAKER));
    check("id read acks", 64'(a), 64'h7);
    wrWord(TARGET_ADDR, CMD_PART_ID, 16'hFFFF, w);
    check("id write acks", 64'(w), 64'hF);
    rdWord(CMD_PART_ID, d, a);
    check("part id", 64'(d), 64'(PART));
    check("settings", settings, expSet);
  endtask
  task automatic tcSettings();
    logic [7:0] cmds [4] = '{CMD_OPTION_CONTROL, CMD_BATTERY_CURRENT, CMD_BATTERY_VOLTAGE,
                             CMD_ADAPTER_LIMIT};
    logic [15:0] vals [4] = '{16'h8001, 16'h1234, 16'hC3A5, 16'h00FF};
    logic [15:0] d;
    logic [2:0] a;
    logic [3:0] w;
    for (int i = 0; i < 4; i++) begin
      wrWord(TARGET_ADDR, cmds[i], vals[i], w);
      expSet[63 - 16 * i -: 16] = vals[i];
      check("write acks", 64'(w), 64'hF);
      check("settings", settings, expSet);
      rdWord(cmds[i], d, a);
      check("read back", 64'(d), 64'(vals[i]));
      check("read acks", 64'(a), 64'h7);
    end
  endtask
  task automatic tcRefused();
    logic [6:0] adrs [3] = '{7'h08, 7'h0A, 7'h49};
    logic [3:0] w;
    logic a;
    for (int i = 0; i < 3; i++) begin
      wrWord(adrs[i], CMD_BATTERY_CURRENT, 16'h5555, w);
      check("foreign address acks", 64'(w), 64'h0);
    end
    wrWord(TARGET_ADDR, 8'h13, 16'h5555, w);
    check("unknown command acks", 64'(w), 64'h8);
    u_host.start();
    u_host.writeByte({TARGET_ADDR, 1'b1}, a);
    u_host.stop();
    check("read without command", 64'(a), 64'h0);
    u_host.start();
    u_host.writeByte({TARGET_ADDR, 1'b0}, a);
    u_host.writeByte(CMD_BATTERY_VOLTAGE, a);
    u_host.writeByte(8'h11, a);
    u_host.stop();
    check("settings", settings, expSet);
  endtask
  task automatic tcTimeout();
    logic a;
    int n;
    u_host.start();
    u_host.writeByte({TARGET_ADDR, 1'b0}, a);
    u_host.writeByte(CMD_ADAPTER_LIMIT, a);
    u_host.writeByte(8'h77, a);
    n = 0;
    while (busActive === 1'b1 && n < 2 * TO_CYC) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2 * TO_CYC) begin
      fail_count++;
      results();
    end
    @(negedge clk_sys);
    check("timeout window", 64'(n > TO_CYC - 10 && n <= TO_CYC + 10), 64'h1);
    check("released", 64'(sdaOe), 64'h0);
    u_host.writeByte(8'h66, a);
    u_host.stop();
    check("late byte acks", 64'(a), 64'h0);
    check("settings", settings, expSet);
  endtask
  task automatic tcDisabled();
    logic [3:0] w;
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys);
      supOk = (i != 0);
      adOk = (i == 0);
      repeat (5) @(negedge clk_sys);
      wrWord(TARGET_ADDR, CMD_BATTERY_CURRENT, 16'hAAAA, w);
      check("disabled acks", 64'(w), 64'h0);
      check("settings", settings, expSet);
    end
    @(negedge clk_sys);
    supOk = 1'b1;
    adOk = 1'b1;
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic tcReset();
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    expSet = {RST_OPTION_CONTROL, RST_BATTERY_CURRENT, RST_BATTERY_VOLTAGE, RST_ADAPTER_LIMIT};
    repeat (5) @(negedge clk_sys);
    check("reset settings", settings, expSet);
    check("reset idle", 64'({busActive, sdaOe}), 64'h0);
    check("data drive level", 64'(sdaOut), 64'h0);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    results();
  end
  initial begin
    tcReset();
    tcIdentity();
    tcSettings();
    tcRefused();
    tcTimeout();
    tcDisabled();
    tcReset();
    results();
  end
endmodule
`default_nettype wire
